//--- core/mftr_pkg.sv
// constants, source enumeration and routing decode for the terminal router
package mftr_pkg;

  // register map
  localparam logic [7:0]  ROUTING_OFFSET = 8'h8c;
  localparam logic [31:0] ROUTING_RESET  = 32'h00001000;
  localparam logic [31:0] ROUTING_MASK   = 32'h0fffffff;

  // field layout
  localparam int unsigned NUM_TERM  = 7;
  localparam int unsigned FIELD_W   = 4;
  localparam int unsigned NUM_GP    = 5;
  localparam int unsigned SCL_TERM  = 4;
  localparam int unsigned SDA_TERM  = 1;
  localparam int unsigned GRANT_TERM = 5;
  localparam int unsigned LOCK_TERM  = 4;

  // internal signals that a terminal can carry
  typedef enum logic [4:0] {
    SRC_INPUT, SRC_GPO, SRC_GRANT, SRC_LOCK,
    SRC_IRQ3, SRC_IRQ4, SRC_IRQ5, SRC_IRQ7, SRC_IRQ9,
    SRC_IRQ10, SRC_IRQ11, SRC_IRQ13, SRC_IRQ15,
    SRC_VSTAT, SRC_VSEL, SRC_AUDIO, SRC_LOWPWR, SRC_LED,
    SRC_GPE, SRC_RING, SRC_INTA, SRC_PREQ
  } mftr_src_t;

  localparam int unsigned NUM_SRC = 22;

  // map one terminal field code to the signal it selects
  function automatic mftr_src_t mftr_route(input int unsigned term,
                                           input logic [3:0] code);
    mftr_src_t s;
    s = SRC_INPUT;
    // codes of terminals three and six are unknown: kept as inputs
    if (term != 3 && term != 6) begin
      unique case (code)
        4'h0: s = SRC_INPUT;
        4'h1: s = SRC_GPO;
        4'h3: s = SRC_IRQ3;
        4'h4: s = SRC_IRQ4;
        4'h6: s = SRC_VSTAT;
        4'h7: s = SRC_VSEL;
        4'h8: s = SRC_AUDIO;
        4'ha: s = SRC_IRQ10;
        4'hb: s = SRC_IRQ11;
        4'he: s = SRC_GPE;
        4'h5: s = (term == 5) ? SRC_LOWPWR : SRC_IRQ5;
        4'h9: s = (term == 5) ? SRC_LOWPWR : SRC_IRQ9;
        4'h2: begin
          unique case (term)
            5: s = SRC_GRANT;
            4: s = SRC_LOCK;
            2: s = SRC_PREQ;
            1: s = SRC_LOWPWR;
            default: s = SRC_INTA;
          endcase
        end
        4'hc: begin
          unique case (term)
            4, 2: s = SRC_RING;
            default: s = SRC_LED;
          endcase
        end
        4'hd: begin
          unique case (term)
            5, 4: s = SRC_LED;
            2: s = SRC_LOWPWR;
            default: s = SRC_IRQ13;
          endcase
        end
        default: begin
          unique case (term)
            4: s = SRC_LOWPWR;
            2: s = SRC_IRQ7;
            default: s = SRC_IRQ15;
          endcase
        end
      endcase
    end
    return s;
  endfunction

endpackage

//--- core/mftr_routing.sv
// multifunction terminal routing register with wishbone slave and pin muxes
`timescale 1ns/1ps
`default_nettype none
// Operation
// - every terminal is an input after reset, a general input on all but three and six; with the serial straps, terminals one and four then go to the serial bus
// - eeprom value may replace the reset default
// - bits 31 to 28 read zero, ignore writes
// - shared codes route irq, video, audio lines
// - terminal five own codes as listed
// - terminal four own codes as listed
// - terminal two own codes as listed
// - terminal one own codes as listed
// - serial mode puts clock on terminal four
module mftr_routing
  import mftr_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic                     wb_ack_o,
  output logic [31:0]              wb_dat_o,
  // eeprom default load
  input  wire logic                eepromLoad,
  input  wire logic [31:0]         eepromData,
  // serial mode straps and serial bus drive
  input  wire logic                powerSwitchCtl0,
  input  wire logic                powerSwitchCtl1,
  input  wire logic                sclOut,
  input  wire logic                sclOe,
  input  wire logic                sdaOut,
  input  wire logic                sdaOe,
  // internal sources
  input  wire logic [15:0]         irqLine,
  input  wire logic [NUM_GP-1:0]   generalOutput,
  input  wire logic                pciInta,
  input  wire logic                pciBusRequest,
  input  wire logic                pciLockOut,
  input  wire logic                pciLockOe,
  input  wire logic                lowPowerStateFlag,
  input  wire logic                socketActivityLed,
  input  wire logic                videoPortStatus,
  input  wire logic                videoPortSelect,
  input  wire logic                cardAudioPwm,
  input  wire logic                generalPurposeEvent,
  input  wire logic                ringIndicateOut,
  // captured terminal inputs and strapped serial mode
  output logic [NUM_GP-1:0]        generalInput,
  output logic                     pciBusGrant,
  output logic                     pciLockIn,
  output logic                     sdaIn,
  output logic                     serialBusMode,
  // multifunction terminals
  input  wire logic [NUM_TERM-1:0] multiTerminalIn,
  output logic [NUM_TERM-1:0]      multiTerminalOut,
  output logic [NUM_TERM-1:0]      multiTerminalOe
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [31:0]         routing_reg,  routing_next;
  logic                wbAck_reg,    wbAck_next;
  logic [31:0]         wbDat_reg,    wbDat_next;
  logic                strapDone_reg, strapDone_next;
  logic                serial_reg,   serial_next;
  logic [NUM_TERM-1:0] termOut_reg,  termOut_next;
  logic [NUM_TERM-1:0] termOe_reg,   termOe_next;
  logic [NUM_GP-1:0]   gpIn_reg,     gpIn_next;
  logic                grant_reg,    grant_next;
  logic                lockIn_reg,   lockIn_next;
  logic                sdaIn_reg,    sdaIn_next;

  logic                request;
  logic                hit;
  logic [31:0]         writeMerged;
  logic [NUM_SRC-1:0]  srcLevel;
  mftr_src_t           termSrc [NUM_TERM];
  logic [NUM_TERM-1:0] muxOut;
  logic [NUM_TERM-1:0] muxOe;
  logic [NUM_TERM-1:0] gpoByTerm;

  assign request = wb_cyc_i && wb_stb_i;
  assign hit     = (wb_adr_i == ROUTING_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // terminal muxes

  always_comb begin
    srcLevel = '0;
    srcLevel[5'(SRC_IRQ3)]   = irqLine[3];
    srcLevel[5'(SRC_IRQ4)]   = irqLine[4];
    srcLevel[5'(SRC_IRQ5)]   = irqLine[5];
    srcLevel[5'(SRC_IRQ7)]   = irqLine[7];
    srcLevel[5'(SRC_IRQ9)]   = irqLine[9];
    srcLevel[5'(SRC_IRQ10)]  = irqLine[10];
    srcLevel[5'(SRC_IRQ11)]  = irqLine[11];
    srcLevel[5'(SRC_IRQ13)]  = irqLine[13];
    srcLevel[5'(SRC_IRQ15)]  = irqLine[15];
    srcLevel[5'(SRC_VSTAT)]  = videoPortStatus;
    srcLevel[5'(SRC_VSEL)]   = videoPortSelect;
    srcLevel[5'(SRC_AUDIO)]  = cardAudioPwm;
    srcLevel[5'(SRC_LOWPWR)] = lowPowerStateFlag;
    srcLevel[5'(SRC_LED)]    = socketActivityLed;
    srcLevel[5'(SRC_GPE)]    = generalPurposeEvent;
    srcLevel[5'(SRC_RING)]   = ringIndicateOut;
    srcLevel[5'(SRC_INTA)]   = pciInta;
    srcLevel[5'(SRC_PREQ)]   = pciBusRequest;
  end

  // general purpose index skips terminals three and six
  assign gpoByTerm = {1'b0, generalOutput[4:3], 1'b0, generalOutput[2:0]};

  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    mftr_term_mux #(.TERM(t)) u_mux (
      .code     (routing_reg[t*FIELD_W +: FIELD_W]),
      .srcLevel (srcLevel),
      .gpoLevel (gpoByTerm[t]),
      .lockOut  (pciLockOut),
      .lockOe   (pciLockOe),
      .src      (termSrc[t]),
      .drvOut   (muxOut[t]),
      .drvOe    (muxOe[t])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      writeMerged[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8]
                                          : routing_reg[i*8 +: 8];
    end
    routing_next = routing_reg;
    // a late eeprom load beats a bus write in the same cycle
    if (eepromLoad) begin
      routing_next = eepromData & ROUTING_MASK;
    end else if (request && wb_we_i && hit && wbAck_reg) begin
      routing_next = writeMerged & ROUTING_MASK;
    end
    // one wait state; ack drops for a cycle so a held strobe is not
    // mistaken for a second request
    wbAck_next = request && !wbAck_reg;
    wbDat_next = wbDat_reg;
    if (request && !wbAck_reg) begin
      wbDat_next = (hit && !wb_we_i) ? routing_reg : 32'h00000000;
    end
    // straps are sampled once, on the first edge after reset release
    strapDone_next = 1'b1;
    serial_next    = strapDone_reg ? serial_reg
                                   : (powerSwitchCtl0 && powerSwitchCtl1);
    termOut_next = muxOut;
    termOe_next  = muxOe;
    if (serial_reg) begin
      termOut_next[SCL_TERM] = sclOut;
      termOe_next[SCL_TERM]  = sclOe;
      termOut_next[SDA_TERM] = sdaOut;
      termOe_next[SDA_TERM]  = sdaOe;
    end
    gpIn_next[0] = multiTerminalIn[0] && termSrc[0] == SRC_INPUT;
    gpIn_next[1] = multiTerminalIn[1] && termSrc[1] == SRC_INPUT
                   && !serial_reg;
    gpIn_next[2] = multiTerminalIn[2] && termSrc[2] == SRC_INPUT;
    gpIn_next[3] = multiTerminalIn[4] && termSrc[4] == SRC_INPUT
                   && !serial_reg;
    gpIn_next[4] = multiTerminalIn[5] && termSrc[5] == SRC_INPUT;
    grant_next  = multiTerminalIn[GRANT_TERM]
                  && termSrc[GRANT_TERM] == SRC_GRANT;
    lockIn_next = multiTerminalIn[LOCK_TERM]
                  && termSrc[LOCK_TERM] == SRC_LOCK && !serial_reg;
    sdaIn_next  = multiTerminalIn[SDA_TERM] && serial_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      routing_reg   <= ROUTING_RESET;
      wbAck_reg     <= 1'b0;
      wbDat_reg     <= 32'h00000000;
      strapDone_reg <= 1'b0;
      serial_reg    <= 1'b0;
      termOut_reg   <= '0;
      termOe_reg    <= '0;
      gpIn_reg      <= '0;
      grant_reg     <= 1'b0;
      lockIn_reg    <= 1'b0;
      sdaIn_reg     <= 1'b0;
    end else begin
      routing_reg   <= routing_next;
      wbAck_reg     <= wbAck_next;
      wbDat_reg     <= wbDat_next;
      strapDone_reg <= strapDone_next;
      serial_reg    <= serial_next;
      termOut_reg   <= termOut_next;
      termOe_reg    <= termOe_next;
      gpIn_reg      <= gpIn_next;
      grant_reg     <= grant_next;
      lockIn_reg    <= lockIn_next;
      sdaIn_reg     <= sdaIn_next;
    end
  end

  assign wb_ack_o         = wbAck_reg;
  assign wb_dat_o         = wbDat_reg;
  assign generalInput     = gpIn_reg;
  assign pciBusGrant      = grant_reg;
  assign pciLockIn        = lockIn_reg;
  assign sdaIn            = sdaIn_reg;
  assign serialBusMode    = serial_reg;
  assign multiTerminalOut = termOut_reg;
  assign multiTerminalOe  = termOe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_reset_all_inputs: assert property (
    !$past(rst_b) |-> termOe_reg == '0 && routing_reg == ROUTING_RESET)
    else $error("terminals not all inputs after reset");

  a_eeprom_load_value: assert property (
    eepromLoad |=> routing_reg == ($past(eepromData) & ROUTING_MASK))
    else $error("eeprom value not loaded");

  a_reserved_read_zero: assert property (
    routing_reg[31:28] == 4'h0 && (!wbAck_reg || wbDat_reg[31:28] == 4'h0))
    else $error("reserved bits not zero");

  a_shared_irq3_route: assert property (
    routing_reg[3:0] == 4'h3 |=> termOut_reg[0] == $past(irqLine[3])
                                 && termOe_reg[0])
    else $error("terminal zero irq3 not routed");

  a_grant_input_route: assert property (
    routing_reg[23:20] == 4'h2 |=> !termOe_reg[5]
                                   && grant_reg == $past(multiTerminalIn[5]))
    else $error("terminal five grant not captured");

  a_t4_lowpower_route: assert property (
    routing_reg[19:16] == 4'hf && !serial_reg
      |=> termOut_reg[4] == $past(lowPowerStateFlag) && termOe_reg[4])
    else $error("terminal four low power flag not routed");

  a_t2_request_route: assert property (
    routing_reg[11:8] == 4'h2 |=> termOut_reg[2] == $past(pciBusRequest))
    else $error("terminal two request not routed");

  a_t1_irq13_route: assert property (
    routing_reg[7:4] == 4'hd && !serial_reg
      |=> termOut_reg[1] == $past(irqLine[13]))
    else $error("terminal one irq13 not routed");

  a_t0_inta_route: assert property (
    routing_reg[3:0] == 4'h2 |=> termOut_reg[0] == $past(pciInta))
    else $error("terminal zero inta not routed");

  a_serial_clock_pin: assert property (
    serial_reg |=> termOut_reg[4] == $past(sclOut)
                   && termOe_reg[4] == $past(sclOe))
    else $error("serial clock not on terminal four");

  a_serial_data_pin: assert property (
    serial_reg |=> termOut_reg[1] == $past(sdaOut)
                   && termOe_reg[1] == $past(sdaOe))
    else $error("serial data not on terminal one");

  a_hidden_field_store: assert property (
    request && wb_we_i && hit && wbAck_reg && wb_sel_i[3] && !eepromLoad
      |=> routing_reg[27:24] == $past(wb_dat_i[27:24]))
    else $error("terminal six field not stored");

  c_bus_write: cover property (request && wb_we_i && hit && wbAck_reg);
  c_bus_read:  cover property (request && !wb_we_i && hit ##1 wbAck_reg);
  c_serial:    cover property (serial_reg);
  c_eeprom:    cover property (eepromLoad);

endmodule
`default_nettype wire

//--- core/mftr_term_mux.sv
// one multifunction terminal: decode its field and pick drive and enable
`timescale 1ns/1ps
`default_nettype none
module mftr_term_mux
  import mftr_pkg::*;
#(
  parameter int unsigned TERM = 0
) (
  // routing field
  input  wire logic [3:0]         code,
  // internal sources
  input  wire logic [NUM_SRC-1:0] srcLevel,
  input  wire logic               gpoLevel,
  input  wire logic               lockOut,
  input  wire logic               lockOe,
  // selection and pin drive
  output mftr_src_t               src,
  output logic                    drvOut,
  output logic                    drvOe
);

  always_comb begin
    src    = mftr_route(TERM, code);
    drvOut = 1'b0;
    drvOe  = 1'b1;
    unique case (src)
      SRC_INPUT, SRC_GRANT: drvOe = 1'b0;
      SRC_GPO: drvOut = gpoLevel;
      SRC_LOCK: begin
        drvOut = lockOut;
        drvOe  = lockOe;
      end
      default: drvOut = srcLevel[5'(src)];
    endcase
  end

endmodule
`default_nettype wire

//--- sim/mftr_board.sv
// board side of the multifunction terminals: wire resolution and straps
`timescale 1ns/1ps
`default_nettype none
module mftr_board (
  // pin drive from the router
  input  wire logic [6:0] pinOut,
  input  wire logic [6:0] pinOe,
  // levels that board parts put on released pins
  input  wire logic [6:0] extLevel,
  input  wire logic       serialStrap,
  // what the router sees
  output logic [6:0]      pinIn,
  output logic            strap0,
  output logic            strap1
);
  // a released pin shows the board's level, never the router's last drive
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : extLevel[i];
    end
  end
  // both pull-ups fitted selects serial mode
  assign strap0 = serialStrap;
  assign strap1 = serialStrap;
endmodule
`default_nettype wire

//--- sim/test_multifunction_terminal_routing.sv
// self-checking bench for the terminal routing register and pin muxes
`timescale 1ns/1ps
`default_nettype none
module test_multifunction_terminal_routing;
  import mftr_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b    = 1'b0;
  logic        wbCyc    = 1'b0;
  logic        wbWe     = 1'b0;
  logic [7:0]  wbAdr    = 8'h00;
  logic [3:0]  wbSel    = 4'h0;
  logic [31:0] wbDat    = 32'h0;
  logic        eeLoad   = 1'b0;
  logic [31:0] eeData   = 32'h0;
  logic [31:0] srcV     = 32'h0;
  logic [3:0]  serDrv   = 4'h0;
  logic [6:0]  extLevel = 7'h00;
  logic        strap    = 1'b0;
  integer      seed     = 32'hdd523af3;
  logic        ack, sMode, grant, lockIn, sdaIn, st0, st1;
  logic [31:0] rdData;
  logic [4:0]  gpIn;
  logic [6:0]  pinIn, pinOut, pinOe;
  logic [31:0] expQ[$];
  int          errTotal = 0;
  int          testsRun = 0;
  int          terms[5] = '{0, 1, 2, 4, 5};

  always #2 core_clk = ~core_clk;

  mftr_board u_board (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel),
    .serialStrap(strap), .pinIn(pinIn), .strap0(st0), .strap1(st1));

  mftr_routing u_dut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbCyc), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDat), .wb_ack_o(ack), .wb_dat_o(rdData),
    .eepromLoad(eeLoad), .eepromData(eeData), .powerSwitchCtl0(st0),
    .powerSwitchCtl1(st1), .sclOut(serDrv[0]), .sclOe(serDrv[1]),
    .sdaOut(serDrv[2]), .sdaOe(serDrv[3]), .irqLine(srcV[15:0]),
    .generalOutput(srcV[20:16]), .pciInta(srcV[21]),
    .pciBusRequest(srcV[22]), .pciLockOut(srcV[23]), .pciLockOe(srcV[24]),
    .lowPowerStateFlag(srcV[25]), .socketActivityLed(srcV[26]),
    .videoPortStatus(srcV[27]), .videoPortSelect(srcV[28]),
    .cardAudioPwm(srcV[29]), .generalPurposeEvent(srcV[30]),
    .ringIndicateOut(srcV[31]), .generalInput(gpIn), .pciBusGrant(grant),
    .pciLockIn(lockIn), .sdaIn(sdaIn), .serialBusMode(sMode),
    .multiTerminalIn(pinIn), .multiTerminalOut(pinOut),
    .multiTerminalOe(pinOe));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hold the request until ack is sampled, then release
  task automatic wbXfer(input logic we, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbWe  <= we;
    wbAdr <= a;
    wbDat <= d;
    wbSel <= s;
    do @(posedge core_clk); while (ack !== 1'b1);
    wbCyc <= 1'b0;
  endtask

  task automatic wbRead(input logic [7:0] a, input logic [31:0] exp);
    expQ.push_back(exp);
    wbXfer(1'b0, a, 32'h0, 4'hf);
  endtask

  // read data is compared at the edge that samples ack
  always @(posedge core_clk) begin
    if (ack === 1'b1 && !wbWe) check(rdData, expQ.pop_front());
  end

  task automatic doReset(input logic s);
    @(posedge core_clk);
    strap <= s;
    rst_b <= 1'b0;
    repeat (1) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  function automatic logic expLvl(input int t, input logic [3:0] c);
    case (c)
      4'h1: return srcV[16 + (t > 3 ? t - 1 : t)];
      4'h2: return t == 4 ? srcV[23] : t == 2 ? srcV[22] :
                   t == 1 ? srcV[25] : srcV[21];
      4'h3: return srcV[3];
      4'h4: return srcV[4];
      4'h5: return t == 5 ? srcV[25] : srcV[5];
      4'h6: return srcV[27];
      4'h7: return srcV[28];
      4'h8: return srcV[29];
      4'h9: return t == 5 ? srcV[25] : srcV[9];
      4'ha: return srcV[10];
      4'hb: return srcV[11];
      4'hc: return (t == 4 || t == 2) ? srcV[31] : srcV[26];
      4'hd: return t > 3 ? srcV[26] : t == 2 ? srcV[25] : srcV[13];
      4'he: return srcV[30];
      default: return t == 4 ? srcV[25] : t == 2 ? srcV[7] : srcV[15];
    endcase
  endfunction

  initial begin
    #40000;
    errTotal++;
    complete_run();
  end

  initial begin
    int t;
    logic [31:0] wv;
    doReset(1'b0);
    check({25'h0, pinOe}, 32'h0);
    wbRead(ROUTING_OFFSET, 32'h00001000);
    wbXfer(1'b1, ROUTING_OFFSET, 32'hffffffff, 4'hf);
    wbRead(ROUTING_OFFSET, 32'h0fffffff);
    check({30'h0, pinOe[6], pinOe[3]}, 32'h0);
    wbXfer(1'b1, ROUTING_OFFSET, 32'h00000000, 4'h1);
    wbXfer(1'b1, 8'h90, 32'h0, 4'hf);
    wbRead(8'h90, 32'h0);
    wbRead(ROUTING_OFFSET, 32'h0fffff00);
    @(posedge core_clk);
    eeLoad <= 1'b1;
    eeData <= 32'hf1234567;
    @(posedge core_clk);
    eeLoad <= 1'b0;
    wbRead(ROUTING_OFFSET, 32'h01234567);
    foreach (terms[k]) begin
      for (int c = 0; c < 16; c++) begin
        t = terms[k];
        wv = 32'h0;
        wv[4*t +: 4] = c[3:0];
        @(posedge core_clk);
        srcV     <= $random(seed);
        extLevel <= 7'($random(seed));
        wbXfer(1'b1, ROUTING_OFFSET, wv, 4'hf);
        repeat (3) @(posedge core_clk);
        #1;
        if (c == 0) begin
          check(pinOe[t], 1'b0);
          check(gpIn[t > 3 ? t - 1 : t], extLevel[t]);
        end else if (t == 5 && c == 2) begin
          check(pinOe[5], 1'b0);
          check(grant, extLevel[5]);
        end else begin
          check(pinOe[t], (t == 4 && c == 2) ? srcV[24] : 1'b1);
          // lock output is only looked at while its enable is asked for
          if (t != 4 || c != 2 || srcV[24])
            check(pinOut[t], expLvl(t, c[3:0]));
          if (t == 4 && c == 2) check(lockIn, pinIn[4]);
        end
      end
    end
    doReset(1'b1);
    check(sMode, 1'b1);
    wbXfer(1'b1, ROUTING_OFFSET, 32'h00000000, 4'hf);
    repeat (4) begin
      @(posedge core_clk);
      serDrv   <= 4'($random(seed));
      extLevel <= 7'($random(seed));
      repeat (3) @(posedge core_clk);
      #1;
      check({pinOe[4], pinOe[4] & pinOut[4]},
            {serDrv[1], serDrv[1] & serDrv[0]});
      check({pinOe[1], pinOe[1] & pinOut[1]},
            {serDrv[3], serDrv[3] & serDrv[2]});
      check(sdaIn, pinIn[1]);
      check({30'h0, gpIn[3], gpIn[1]}, 32'h0);
    end
    doReset(1'b0);
    check(sMode, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
